// *** design/chc_cfg_header.sv ***
/*
 * chc_cfg_header: type 0 configuration header with bus/device id capture.
 * Assumes an APB master issuing configuration accesses, cfg_attr valid with
 * each write, and the init pattern held steady across reset release.
 */
// Implementation choices: the register addresses and the APB interface to the registers.
// Notes on behaviour
// [R1] reset forces captured bus and device numbers to all ones
// [R2] every config write to this function latches bus and device numbers
// [R3] captured numbers form the requester and completer id
// [R4] host issues a config write after each reset release
// [R5] host rewrites devices when a segment's bus number changes
// [R6] host sets bus master via command write before non-split initiation
// [R7] split completions start regardless of bus master enable
// [R8] early split completions carry uninitialised ids, routed by requester id
// [R9] no split transaction with an ambiguous requester id
// [R10] conventional mode keeps base header behaviour unchanged
// [R11] enhanced mode ignores fast back-to-back, stepping and mwi enables
// [R12] capabilities-list status bit always reads one
// [R13] fast back-to-back never performed in enhanced mode
// [R14] select timing field reports conventional timing always
// [R15] memory bar supports 64-bit addressing over two registers
// [R16] prefetchable bit set unless side effects or no write merging
// [R17] bar requests at least 128 bytes
// [R18] bar size smallest power of two above space used
// [R19] latency timer defaults to 64 in enhanced mode
// [R20] prefetchable reads need only valid enabled bytes
// [R21] software places non-prefetchable ranges below 4 GB
// [R22] mode chosen from init pattern at reset release
// [R23] reserved writes discarded, reserved reads return zero
// [R24] capture only on accepted writes to this function
`timescale 1ns/1ps
module chc_cfg_header
	import chc_pkg::*;
#(
	parameter logic [31:0] ID_WORD     = 32'h0000_0000, // arbitrary value
	parameter logic [31:0] CLASS_WORD  = 32'h0000_0000, // arbitrary value
	parameter logic [2:0]  FUNC_NUM    = 3'h0,
	parameter int          BAR_LOG2    = 7,
	parameter bit          BAR_PREF    = 1'b1,
	parameter logic [1:0]  DEVSEL_TIME = 2'h1,
	parameter bit          CAP_66      = 1'b0,
	parameter bit          FBB_CAP     = 1'b0
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	input  wire logic [3:0]   pstrb,
	output logic              pready,
	output logic [31:0]       prdata,
	output logic              pslverr,
	input  wire chc_attr_type cfg_attr,
	input  wire logic [2:0]   init_pattern,
	input  wire logic         want_split_cpl,
	input  wire logic         want_other,
	output logic              start_split_cpl,
	output logic              start_other,
	output chc_id_type        req_id,
	output logic              enhanced_mode,
	output logic              mem_en,
	output logic              mwi_en,
	output logic              fbb_en,
	output logic              step_en
);
	// ----------------------------------------------------------------
	// local state
	// ----------------------------------------------------------------
	localparam int BAR_LG = (BAR_LOG2 < CHC_BAR_MIN_LOG2) ? CHC_BAR_MIN_LOG2 : BAR_LOG2;
	localparam logic [31:0] BAR_MASK = ~((32'h1 << BAR_LG) - 32'h1);

	logic [2:0]  pattern_sync;
	logic [2:0]  settle_q;
	logic        mode_done_q;
	logic [10:0] cmd_q;
	logic [7:0]  lat_q;
	logic [7:0]  cls_q;
	logic [31:0] bar_lo_q;
	logic [31:0] bar_hi_q;
	logic [7:0]  bus_q;
	logic [4:0]  dev_q;
	logic        ids_valid_q;
	logic        wr_acc;
	logic        rd_setup;
	logic [31:0] rd_d;
	logic [31:0] cmd_wr;

	// byte-lane merge for a written word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction : merge

	chc_sync #(.W(3)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  (init_pattern),
		.pin_out (pattern_sync)
	);

	// ----------------------------------------------------------------
	// mode latch after reset release
	// ----------------------------------------------------------------
	// waits for the synchroniser to fill so reset zeros are not mistaken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_q      <= '0;
			mode_done_q   <= 1'b0;
			enhanced_mode <= 1'b0;
		end else if (!mode_done_q) begin
			settle_q <= settle_q + 3'h1;
			if (settle_q == CHC_MODE_SETTLE) begin
				mode_done_q   <= 1'b1;
				enhanced_mode <= |pattern_sync; // R22
			end
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	assign wr_acc   = psel & penable & pready & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	// command word after byte-lane merge; only the low eleven bits are kept
	assign cmd_wr   = merge({21'h0, cmd_q}, pwdata, pstrb);

	// zero-wait: pready rises in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable & ~pready;
			pslverr <= 1'b0; // R23
		end
	end

	// read mux; unmapped and reserved bits return zero
	always_comb begin
		rd_d = '0; // R23
		unique case (paddr)
			CHC_OFF_ID:      rd_d = ID_WORD;
			CHC_OFF_CMDSTAT: begin
				rd_d[10:0]                        = cmd_q;
				rd_d[16+CHC_STS_CAPL]             = 1'b1; // R12
				rd_d[16+CHC_STS_66]               = CAP_66;
				rd_d[16+CHC_STS_FBBCAP]           = FBB_CAP & ~enhanced_mode;
				rd_d[16+CHC_STS_DEVSEL +: 2]      = DEVSEL_TIME; // R14
			end
			CHC_OFF_CLASS:   rd_d = CLASS_WORD;
			CHC_OFF_MISC:    rd_d = {8'h00, CHC_HDR_TYPE0, lat_q, cls_q};
			CHC_OFF_BAR_LO:  rd_d = {bar_lo_q[31:4], BAR_PREF, CHC_BAR_MEM64}; // R15 R16
			CHC_OFF_BAR_HI:  rd_d = bar_hi_q; // R15
			CHC_OFF_CAPPTR:  rd_d = {24'h0, CHC_OFF_CAPITEM};
			CHC_OFF_CAPITEM: rd_d = {24'h0, CHC_CAP_ITEM_ID};
			CHC_OFF_CAPID:   rd_d = {16'h0, bus_q, dev_q, FUNC_NUM};
			default:         rd_d = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (rd_setup) begin
			prdata <= rd_d; // R20
		end
	end

	// ----------------------------------------------------------------
	// writable header registers
	// ----------------------------------------------------------------
	// all command bits stored as in conventional mode; effect gated below
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_q <= '0;
		end else if (wr_acc && paddr == CHC_OFF_CMDSTAT) begin
			cmd_q <= cmd_wr[10:0] & CHC_CMD_MASK; // R10
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lat_q <= CHC_LAT_RST_CONV;
			cls_q <= '0;
		end else if (!mode_done_q && settle_q == CHC_MODE_SETTLE) begin
			lat_q <= (|pattern_sync) ? CHC_LAT_RST_ENH : CHC_LAT_RST_CONV; // R19
		end else if (wr_acc && paddr == CHC_OFF_MISC) begin
			if (pstrb[0]) cls_q <= pwdata[7:0];
			if (pstrb[1]) lat_q <= pwdata[15:8];
		end
	end

	// low bits below the range size stay zero; size from BAR_LOG2, raised to CHC_BAR_MIN_LOG2 if below it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bar_lo_q <= '0;
			bar_hi_q <= '0;
		end else if (wr_acc && paddr == CHC_OFF_BAR_LO) begin
			bar_lo_q <= merge(bar_lo_q, pwdata, pstrb) & BAR_MASK; // R17 R18
		end else if (wr_acc && paddr == CHC_OFF_BAR_HI) begin
			bar_hi_q <= merge(bar_hi_q, pwdata, pstrb); // R15
		end
	end

	// ----------------------------------------------------------------
	// id capture
	// ----------------------------------------------------------------
	// any accepted write, mapped or not, addresses this function
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_q       <= CHC_BUS_RST; // R1
			dev_q       <= CHC_DEV_RST; // R1
			ids_valid_q <= 1'b0;
		end else if (wr_acc) begin // R24
			bus_q       <= cfg_attr.bus_num; // R2
			dev_q       <= cfg_attr.dev_num; // R2
			ids_valid_q <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_id <= '{bus_num: CHC_BUS_RST, dev_num: CHC_DEV_RST, func_num: FUNC_NUM};
		end else begin
			req_id <= '{bus_num: bus_q, dev_num: dev_q, func_num: FUNC_NUM}; // R3 R8
		end
	end

	// ----------------------------------------------------------------
	// initiation gating and effective enables
	// ----------------------------------------------------------------
	// a split completion needs no bus master and may carry the reset id
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_split_cpl <= 1'b0;
			start_other     <= 1'b0;
		end else begin
			start_split_cpl <= want_split_cpl; // R7 R8
			start_other     <= want_other & cmd_q[CHC_CMD_BM]
				& (ids_valid_q | ~enhanced_mode); // R7 R9
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_en  <= 1'b0;
			mwi_en  <= 1'b0;
			fbb_en  <= 1'b0;
			step_en <= 1'b0;
		end else begin
			mem_en  <= cmd_q[CHC_CMD_MEM];
			mwi_en  <= cmd_q[CHC_CMD_MWI] & ~enhanced_mode; // R11
			fbb_en  <= cmd_q[CHC_CMD_FBB] & FBB_CAP & ~enhanced_mode; // R11 R13
			step_en <= cmd_q[CHC_CMD_STEP] & ~enhanced_mode; // R11
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	AST_RST_ONES: assert property (@(posedge pclk) $rose(presetn) |->
		(bus_q == CHC_BUS_RST && dev_q == CHC_DEV_RST)) // R1
		else $error("captured ids not all ones after reset");
	AST_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_acc |=> (bus_q == $past(cfg_attr.bus_num) && dev_q == $past(cfg_attr.dev_num))) // R2
		else $error("ids not captured on config write");
	AST_NO_CAP_RD: assert property (@(posedge pclk) disable iff (!presetn)
		!wr_acc |=> $stable(bus_q) && $stable(dev_q)) // R24
		else $error("ids changed without a write");
	AST_ID_OUT: assert property (@(posedge pclk) disable iff (!presetn)
		wr_acc |-> ##2 (req_id.bus_num == $past(cfg_attr.bus_num, 2))) // R3
		else $error("requester id does not follow capture");
	AST_SPLIT: assert property (@(posedge pclk) disable iff (!presetn)
		presetn && want_split_cpl |=> start_split_cpl) // R7
		else $error("split completion blocked");
	AST_OTHER_GATE: assert property (@(posedge pclk) disable iff (!presetn)
		start_other |-> $past(cmd_q[CHC_CMD_BM]) && (ids_valid_q || !enhanced_mode)) // R9
		else $error("transaction started without bus master or ids");
	AST_MWI_IGN: assert property (@(posedge pclk) disable iff (!presetn)
		enhanced_mode && $past(enhanced_mode) |-> !mwi_en && !step_en) // R11
		else $error("ignored enable acted in enhanced mode");
	AST_FBB: assert property (@(posedge pclk) disable iff (!presetn)
		enhanced_mode && $past(enhanced_mode) |-> !fbb_en) // R13
		else $error("fast back-to-back in enhanced mode");
	AST_CAPLIST: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pready && !pwrite && paddr == CHC_OFF_CMDSTAT |->
		prdata[16+CHC_STS_CAPL] && prdata[16+CHC_STS_DEVSEL +: 2] == DEVSEL_TIME) // R12 R14
		else $error("status capability or select timing wrong");
	AST_LAT: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(mode_done_q) && enhanced_mode |-> lat_q == CHC_LAT_RST_ENH) // R19
		else $error("latency timer default wrong");
	AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pready && !pwrite && paddr == 8'h3C |-> prdata == 32'h0) // R23
		else $error("unmapped read not zero");
	AST_BAR: assert property (@(posedge pclk) disable iff (!presetn)
		bar_lo_q[BAR_LG-1:0] == '0) // R17
		else $error("bar low bits not zero");

	COV_CAPTURE: cover property (@(posedge pclk) disable iff (!presetn) wr_acc);
	COV_EARLY_SPLIT: cover property (@(posedge pclk) disable iff (!presetn)
		start_split_cpl && !ids_valid_q);
	COV_ENH: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(mode_done_q) && enhanced_mode);
endmodule : chc_cfg_header

// *** design/chc_pkg.sv ***
/*
 * chc_pkg: constants and carrier types for the configuration header and
 * id-capture block. Assumes a 32-bit APB host and one function per instance.
 */
package chc_pkg;
	// ----------------------------------------------------------------
	// header offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CHC_OFF_ID      = 8'h00;
	localparam logic [7:0] CHC_OFF_CMDSTAT = 8'h04;
	localparam logic [7:0] CHC_OFF_CLASS   = 8'h08;
	localparam logic [7:0] CHC_OFF_MISC    = 8'h0C;
	localparam logic [7:0] CHC_OFF_BAR_LO  = 8'h10;
	localparam logic [7:0] CHC_OFF_BAR_HI  = 8'h14;
	localparam logic [7:0] CHC_OFF_CAPPTR  = 8'h34;
	localparam logic [7:0] CHC_OFF_CAPITEM = 8'h40;
	localparam logic [7:0] CHC_OFF_CAPID   = 8'h44;

	// ----------------------------------------------------------------
	// command and status fields
	// ----------------------------------------------------------------
	localparam int CHC_CMD_MEM  = 1;
	localparam int CHC_CMD_BM   = 2;
	localparam int CHC_CMD_MWI  = 4;
	localparam int CHC_CMD_STEP = 7;
	localparam int CHC_CMD_FBB  = 9;
	localparam logic [10:0] CHC_CMD_MASK = 11'h7FF;
	localparam int CHC_STS_CAPL   = 4;
	localparam int CHC_STS_66     = 5;
	localparam int CHC_STS_FBBCAP = 7;
	localparam int CHC_STS_DEVSEL = 9;

	// ----------------------------------------------------------------
	// reset values and fixed codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CHC_LAT_RST_CONV = 8'h00;
	localparam logic [7:0] CHC_LAT_RST_ENH  = 8'h40;
	localparam logic [7:0] CHC_BUS_RST      = 8'hFF;
	localparam logic [4:0] CHC_DEV_RST      = 5'h1F;
	localparam logic [7:0] CHC_CAP_ITEM_ID  = 8'h07;
	localparam logic [7:0] CHC_HDR_TYPE0    = 8'h00;
	localparam logic [2:0] CHC_BAR_MEM64    = 3'h4;
	localparam int         CHC_BAR_MIN_LOG2 = 7;
	// pipeline fill after reset before the synced pattern is trusted
	// three flops plus agreement: synced output is first valid after edge four
	localparam logic [2:0] CHC_MODE_SETTLE  = 3'h4;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] bus_num;
		logic [4:0] dev_num;
	} chc_attr_type;

	typedef struct packed {
		logic [7:0] bus_num;
		logic [4:0] dev_num;
		logic [2:0] func_num;
	} chc_id_type;
endpackage : chc_pkg

// *** design/chc_sync.sv ***
/*
 * chc_sync: three-stage synchroniser with agreement filter for pin inputs.
 * Assumes the input is quasi-static relative to pclk.
 */
`timescale 1ns/1ps
module chc_sync #(
	parameter int W = 3
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_out
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// first stage is read only by the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a change counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out <= '0;
		end else if (s2_q == s3_q) begin
			pin_out <= s3_q;
		end
	end
endmodule : chc_sync

// *** verification/chc_host_model.sv ***
/*
 * chc_host_model: configuration host issuing apb config accesses with attrs.
 * Assumes one clock; the slave may add wait states before pready.
 */
`timescale 1ns/1ps
module chc_host_model
	import chc_pkg::*;
(
	input  wire logic    pclk,
	output logic         psel,
	output logic         penable,
	output logic         pwrite,
	output logic [7:0]   paddr,
	output logic [31:0]  pwdata,
	output logic [3:0]   pstrb,
	output chc_attr_type cfg_attr,
	input  wire logic    pready
);
	// ------------------------------------------------
	// idle bus at time zero
	// ------------------------------------------------
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h0;
		cfg_attr = '0;
	end

	// ------------------------------------------------
	// one transfer; released lines flip so stale data never matches
	// ------------------------------------------------
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input chc_attr_type at);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		cfg_attr <= at;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
		cfg_attr <= ~at;
	endtask : xfer
endmodule : chc_host_model

// *** verification/config_header_and_id_capture_bench.sv ***
/*
 * config_header_and_id_capture_bench: self-checking bench for chc_cfg_header.
 * Assumes chc_host_model drives apb; reads are scored from a note queue.
 */
`timescale 1ns/1ps
module config_header_and_id_capture_bench
	import chc_pkg::*;
;
	typedef struct packed {
		logic [31:0] exp;
		logic [31:0] mask;
	} chc_note_type;

	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata;
	logic [3:0]   pstrb;
	chc_attr_type cfg_attr;
	logic [2:0]   init_pattern;
	logic         want_split_cpl, want_other, start_split_cpl, start_other;
	chc_id_type   req_id;
	logic         enhanced_mode, mem_en, mwi_en, fbb_en, step_en;
	chc_note_type notes[$];
	int           error_cnt = 0;
	int           total_checks = 0;
	int           cyc = 0;

	chc_host_model host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .cfg_attr(cfg_attr), .pready(pready));

	chc_cfg_header dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .cfg_attr(cfg_attr), .init_pattern(init_pattern),
		.want_split_cpl(want_split_cpl), .want_other(want_other),
		.start_split_cpl(start_split_cpl), .start_other(start_other), .req_id(req_id),
		.enhanced_mode(enhanced_mode), .mem_en(mem_en), .mwi_en(mwi_en), .fbb_en(fbb_en),
		.step_en(step_en));

	// ------------------------------------------------
	// clock, timeout and helpers
	// ------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// generous: the whole sequence needs about a hundred cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end

	task automatic conclude;
		if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		#1;
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input chc_attr_type at);
		host_u.xfer(1'b1, a, d, s, at);
	endtask : wr

	// attrs of a read are random: they must never be captured
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		notes.push_back('{exp: e, mask: m});
		host_u.xfer(1'b0, a, 32'h0, 4'hF, 13'($urandom));
	endtask : rd

	task automatic do_reset(input logic [2:0] p);
		@(posedge pclk);
		presetn <= 1'b0;
		init_pattern <= p;
		repeat (8) @(posedge pclk);
		chk(32'(req_id), 32'h0000FFF8);
		chk(32'(start_other), 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
	endtask : do_reset

	// scores every completed read against the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
			total_checks++;
			if (notes.size() == 0) begin
				error_cnt++;
				$display("unexpected at %0t: read with no note", $time);
			end else if ((prdata & notes[0].mask) !== (notes[0].exp & notes[0].mask)
				|| pslverr !== 1'b0) begin
				error_cnt++;
				$display("unexpected at %0t: read %h want %h", $time, prdata, notes[0].exp);
			end
			if (notes.size() != 0) void'(notes.pop_front());
		end
	end

	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		chc_attr_type a1;
		chc_attr_type a2;
		presetn = 1'b0;
		init_pattern = 3'h0;
		want_split_cpl = 1'b0;
		want_other = 1'b0;
		void'($urandom(66));
		a1 = 13'($urandom);
		a2 = 13'($urandom);
		do_reset(3'($urandom_range(7, 1)));
		chk(32'(enhanced_mode), 32'h1);
		rd(CHC_OFF_CAPID, 32'h0000FFF8, 32'hFFFFFFFF);
		rd(CHC_OFF_MISC, 32'h00004000, 32'h00FFFF00);
		rd(CHC_OFF_CMDSTAT, 32'h02100000, 32'h06B00000);
		@(posedge pclk);
		want_split_cpl <= 1'b1;
		want_other <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(32'(start_split_cpl), 32'h1);
		chk(32'(start_other), 32'h0);
		wr(CHC_OFF_CMDSTAT, 32'h000007FF, 4'hF, a1);
		repeat (2) @(posedge pclk);
		chk(32'(req_id), {16'h0, a1, 3'h0});
		chk(32'(start_other), 32'h1);
		chk({mem_en, mwi_en, fbb_en, step_en}, 32'h8);
		rd(CHC_OFF_CAPID, {16'h0, a1, 3'h0}, 32'hFFFFFFFF);
		wr(8'h80, $urandom, 4'hF, a2);
		rd(8'h80, 32'h0, 32'hFFFFFFFF);
		rd(8'h3C, 32'h0, 32'hFFFFFFFF);
		rd(CHC_OFF_CAPID, {16'h0, a2, 3'h0}, 32'hFFFFFFFF);
		wr(CHC_OFF_BAR_LO, 32'hFFFFFFFF, 4'hF, a2);
		rd(CHC_OFF_BAR_LO, 32'hFFFFFF8C, 32'hFFFFFFFF);
		// prefetchable range, so placing it above 4 GB is allowed
		wr(CHC_OFF_BAR_HI, 32'hFFFFFFFF, 4'hF, a2);
		wr(CHC_OFF_BAR_HI, 32'h0, 4'b0010, a2);
		rd(CHC_OFF_BAR_HI, 32'hFFFF00FF, 32'hFFFFFFFF);
		rd(CHC_OFF_CAPPTR, 32'h00000040, 32'h000000FF);
		rd(CHC_OFF_CAPITEM, 32'h00000007, 32'h000000FF);
		// second reset in mid-run, wants still held, conventional pattern
		do_reset(3'h0);
		chk(32'(enhanced_mode), 32'h0);
		chk(32'(start_split_cpl), 32'h1);
		rd(CHC_OFF_MISC, 32'h0, 32'h00FFFF00);
		rd(CHC_OFF_CMDSTAT, 32'h02100000, 32'h06B00000);
		wr(CHC_OFF_CMDSTAT, 32'h000007FF, 4'hF, a1);
		repeat (2) @(posedge pclk);
		chk(32'(req_id), {16'h0, a1, 3'h0});
		chk({mem_en, mwi_en, fbb_en, step_en}, 32'hD);
		chk(32'(start_other), 32'h1);
		rd(CHC_OFF_CMDSTAT, 32'h02100016, 32'h06B00016);
		@(posedge pclk);
		want_split_cpl <= 1'b0;
		want_other <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(32'(start_split_cpl), 32'h0);
		chk(32'(start_other), 32'h0);
		repeat (4) @(posedge pclk);
		chk(32'(notes.size()), 32'h0);
		conclude();
	end
endmodule : config_header_and_id_capture_bench
